// file: pei_top.sv
`timescale 1ns/100ps
// Operation
// [R1] long debounced press forces soft-off, deep sleep
// [R2] override acts in any state, no handshake
// [R3] override period configurable, default four seconds
// [R4] soft-off may start after extra latency
// [R5] debounce select zero adds 16 ms
// [R6] level status after or before debounce
// [R7] platform holds button released 500 us
// [R8] wake needs press of 150 us
// [R9] falling wake edge raises event, rising none
// [R10] internal wake request sets wake status
// [R11] reset button detection starts host reset
// [R12] host reset held 5 to 6 ms
// [R13] rearm after release, S0, platform reset off
// [R14] control bit 3 selects full power cycle
// [R15] reset button only acts with power ok
// [R16] thermal trip drops sleep outputs, sets status
// [R17] trip low glitches under 25 ns ignored
// [R18] trip monitoring window by valid point
// [R19] thermal trip clears button event status
// [R20] holdoff delays resume after sleep exit
// [R21] holdoff ignored outside entry with sleep asserted
// [R22] no flash access while sleep or holdoff
// [R23] override counter restarts on early release
// [R24] controller watches flash select 5 ms
module pei_top #(
  parameter int unsigned DEBOUNCE_CYCLES = pei_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOST_RST_CYCLES = pei_pkg::HOST_RST_CYC,
  parameter int unsigned SEC_CYCLES = pei_pkg::SEC_CYC,
  parameter int unsigned WAKE_CYCLES = pei_pkg::WAKE_MIN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic thermal_trip_n,
  input wire logic pci_wake_n,
  input wire logic internal_wake_req,
  input wire logic platform_reset_n,
  input wire logic processor_power_good,
  input wire logic hub_power_ok,
  input wire logic resume_holdoff_n,
  input wire logic sleep_always_on_n,
  input wire logic in_s0,
  input wire logic sx_entry,
  input wire logic deep_sleep_ok,
  input wire pei_pkg::pei_cfg_t cfg,
  input wire logic button_event_set,
  input wire logic button_event_clear,
  input wire logic wake_status_clear,
  input wire logic trip_status_clear,
  output logic button_level_status,
  output logic button_event_status,
  output logic button_wake,
  output logic internal_wake_status,
  output logic pci_wake_event,
  output logic override_soft_off,
  output logic override_deep_sleep,
  output logic host_reset,
  output logic full_power_cycle,
  output pei_pkg::pei_sleep_t sleep_out,
  output logic prior_trip_status,
  output logic resume_hold,
  output logic flash_block
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pins_s;

  pei_sync #(.W(7), .RST_VAL(7'h7f)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({power_button_n, reset_button_n, thermal_trip_n, pci_wake_n,
        platform_reset_n, resume_holdoff_n, sleep_always_on_n}),
    .q(pins_s)
  );

  logic pb_raw_n;
  logic rb_raw_n;
  logic tt_raw_n;
  logic pw_n;
  logic prst_n;
  logic hold_n;
  logic slpa_n;
  assign {pb_raw_n, rb_raw_n, tt_raw_n, pw_n, prst_n, hold_n, slpa_n} = pins_s;

  logic ppg_s;
  logic pok_s;

  pei_sync #(.W(2), .RST_VAL(2'h0)) u_sync_pg (
    .clk(clk),
    .rst(rst),
    .d({processor_power_good, hub_power_ok}),
    .q({ppg_s, pok_s})
  );

  // ----------------------------------------------------------------
  // debounce
  // ----------------------------------------------------------------
  logic pb_db_n;
  logic rb_db_n;
  logic tt_flt_n;

  pei_filter #(.LEN(DEBOUNCE_CYCLES), .RST_VAL(1'b1)) u_pb_db ( // [R5]
    .clk(clk),
    .rst(rst),
    .d(pb_raw_n),
    .q(pb_db_n)
  );

  pei_filter #(.LEN(DEBOUNCE_CYCLES), .RST_VAL(1'b1)) u_rb_db (
    .clk(clk),
    .rst(rst),
    .d(rb_raw_n),
    .q(rb_db_n)
  );

  // one sample more than a short glitch can ever straddle
  pei_filter #(.LEN(pei_pkg::TRIP_GLITCH_CYC + 1), .RST_VAL(1'b1)) u_tt_flt ( // [R17]
    .clk(clk),
    .rst(rst),
    .d(tt_raw_n),
    .q(tt_flt_n)
  );

  // debounce select 1 bypasses the 16 ms filter
  logic pb_use_n;
  assign pb_use_n = cfg.button_debounce_select ? pb_raw_n : pb_db_n; // [R5]
  logic rb_use_n;
  assign rb_use_n = cfg.button_debounce_select ? rb_raw_n : rb_db_n; // [R11]

  // ----------------------------------------------------------------
  // button level and wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      button_level_status <= 1'b0;
    else
      button_level_status <= ~pb_use_n; // [R6]
  end

  // short presses never count as a wake
  logic [31:0] wake_cnt_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_cnt_r <= 32'h0;
      button_wake <= 1'b0;
    end
    else
    begin
      button_wake <= 1'b0;
      if (pb_use_n)
        wake_cnt_r <= 32'h0;
      else if (wake_cnt_r + 32'h1 == WAKE_CYCLES) // [R8]
      begin
        wake_cnt_r <= wake_cnt_r + 32'h1;
        button_wake <= 1'b1;
      end
      else if (wake_cnt_r < WAKE_CYCLES)
        wake_cnt_r <= wake_cnt_r + 32'h1;
    end
  end

  logic trip_event;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      button_event_status <= 1'b0;
    else if (trip_event)
      button_event_status <= 1'b0; // [R19]
    else if (button_event_set || button_wake)
      button_event_status <= 1'b1;
    else if (button_event_clear)
      button_event_status <= 1'b0;
  end

  // ----------------------------------------------------------------
  // power button override
  // ----------------------------------------------------------------
  logic [31:0] ovr_cnt_r;
  logic [3:0] ovr_sec_r;
  logic [3:0] ovr_target;
  assign ovr_target = pei_pkg::pei_ovr_seconds(cfg.override_period_select); // [R3]

  // no power-ok or processor term: override must work on a hung system
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_cnt_r <= 32'h0;
      ovr_sec_r <= 4'h0;
      override_soft_off <= 1'b0;
      override_deep_sleep <= 1'b0;
    end
    else if (pb_db_n) // [R23]
    begin
      ovr_cnt_r <= 32'h0;
      ovr_sec_r <= 4'h0;
      override_soft_off <= 1'b0;
      override_deep_sleep <= 1'b0;
    end
    else if (ovr_sec_r >= ovr_target) // [R1] [R2]
    begin
      // soft-off asserted without added latency, well inside the allowance
      override_soft_off <= 1'b1; // [R4]
      override_deep_sleep <= deep_sleep_ok;
    end
    else if (ovr_cnt_r + 32'h1 >= SEC_CYCLES)
    begin
      ovr_cnt_r <= 32'h0;
      ovr_sec_r <= ovr_sec_r + 4'h1;
    end
    else
      ovr_cnt_r <= ovr_cnt_r + 32'h1;
  end

  // ----------------------------------------------------------------
  // wake events
  // ----------------------------------------------------------------
  logic pw_d_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pw_d_r <= 1'b1;
      pci_wake_event <= 1'b0;
    end
    else
    begin
      pw_d_r <= pw_n;
      pci_wake_event <= pw_d_r & ~pw_n | internal_wake_req; // [R9] [R10]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      internal_wake_status <= 1'b0;
    else if (internal_wake_req)
      internal_wake_status <= 1'b1; // [R10]
    else if (wake_status_clear)
      internal_wake_status <= 1'b0;
  end

  // ----------------------------------------------------------------
  // reset button
  // ----------------------------------------------------------------
  pei_pkg::pei_rb_state_t rb_state_r;
  logic [31:0] rb_cnt_r;
  logic rb_use_d_r;
  logic rb_fall;
  assign rb_fall = rb_use_d_r & ~rb_use_n;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rb_use_d_r <= 1'b1;
    else
      rb_use_d_r <= rb_use_n;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rb_state_r <= pei_pkg::PEI_RB_IDLE;
      rb_cnt_r <= 32'h0;
      host_reset <= 1'b0;
      full_power_cycle <= 1'b0;
    end
    else
    begin
      unique case (rb_state_r)
        pei_pkg::PEI_RB_IDLE:
        begin
          if (rb_fall && pok_s) // [R11] [R15]
          begin
            rb_state_r <= pei_pkg::PEI_RB_PULSE;
            rb_cnt_r <= 32'h0;
            host_reset <= 1'b1;
            full_power_cycle <= cfg.reset_control[pei_pkg::RST_CTRL_FULL_BIT]; // [R14]
          end
        end
        pei_pkg::PEI_RB_PULSE:
        begin
          if (rb_cnt_r + 32'h1 >= HOST_RST_CYCLES) // [R12]
          begin
            rb_state_r <= pei_pkg::PEI_RB_BLOCK;
            host_reset <= 1'b0;
            full_power_cycle <= 1'b0;
          end
          else
            rb_cnt_r <= rb_cnt_r + 32'h1;
        end
        pei_pkg::PEI_RB_BLOCK:
        begin
          if (rb_db_n && in_s0 && prst_n) // [R13]
            rb_state_r <= pei_pkg::PEI_RB_IDLE;
        end
        default:
          rb_state_r <= pei_pkg::PEI_RB_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // thermal trip
  // ----------------------------------------------------------------
  logic trip_mon_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      trip_mon_r <= 1'b0;
    else if (!ppg_s)
      trip_mon_r <= 1'b0; // [R18]
    else if (cfg.trip_valid_point ? ppg_s : prst_n)
      trip_mon_r <= 1'b1; // [R18]
  end

  assign trip_event = trip_mon_r & ~tt_flt_n;

  // direct drive, no handshake: a hot die may not finish one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sleep_out <= '1;
    else if (trip_event)
      sleep_out <= '0; // [R16]
    else if (override_soft_off)
      sleep_out <= '0; // [R1]
    else if (in_s0)
      sleep_out <= '1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prior_trip_status <= 1'b0;
    else if (trip_event)
      prior_trip_status <= 1'b1; // [R16]
    else if (trip_status_clear)
      prior_trip_status <= 1'b0;
  end

  // ----------------------------------------------------------------
  // resume holdoff and flash gating
  // ----------------------------------------------------------------
  logic hold_arm_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_arm_r <= 1'b0;
    else if (!cfg.holdoff_enable || in_s0)
      hold_arm_r <= 1'b0; // [R21]
    else if (sx_entry && !slpa_n)
      hold_arm_r <= 1'b1; // [R21]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      resume_hold <= 1'b0;
      flash_block <= 1'b1;
    end
    else
    begin
      resume_hold <= hold_arm_r & ~hold_n; // [R20]
      flash_block <= ~slpa_n | (hold_arm_r & ~hold_n); // [R22]
    end
  end

endmodule

// file: pei_pkg.sv
package pei_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_MIN_US = 150;
  localparam int unsigned WAKE_MIN_CYC = WAKE_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOST_RST_MIN_MS = 5;
  localparam int unsigned HOST_RST_MAX_MS = 6;
  // hold reset at the minimum; exact at this clock, still below the maximum
  localparam int unsigned HOST_RST_CYC = HOST_RST_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned TRIP_GLITCH_NS = 25;
  localparam int unsigned TRIP_GLITCH_CYC =
    (TRIP_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRIP_MAX_NS = 1000;
  localparam int unsigned OVERRIDE_DEFAULT_S = 4;
  localparam int unsigned OVERRIDE_LATENCY_MS = 1300;
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------
  // configuration fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned OVR_SEL_W = 3;
  localparam logic [2:0] OVR_SEL_RST = 3'h0; // 0 -> four seconds
  localparam int unsigned RST_CTRL_FULL_BIT = 3;
  localparam logic DB_SEL_RST = 1'b0;
  localparam logic TRIP_VALID_RST = 1'b0;

  typedef struct packed {
    logic button_debounce_select;
    logic [2:0] override_period_select;
    logic trip_valid_point;
    logic [7:0] reset_control;
    logic holdoff_enable;
  } pei_cfg_t;

  typedef struct packed {
    logic sleep_s3_n;
    logic sleep_s4_n;
    logic sleep_s5_n;
  } pei_sleep_t;

  typedef enum logic [1:0]
  {
    PEI_RB_IDLE = 2'b00,
    PEI_RB_PULSE = 2'b01,
    PEI_RB_BLOCK = 2'b10
  } pei_rb_state_t;

  // override period in seconds per select code
  function automatic logic [3:0] pei_ovr_seconds(input logic [2:0] sel);
    case (sel)
      3'h1: pei_ovr_seconds = 4'h6;
      3'h2: pei_ovr_seconds = 4'h8;
      3'h3: pei_ovr_seconds = 4'ha;
      3'h4: pei_ovr_seconds = 4'hc;
      3'h5: pei_ovr_seconds = 4'he;
      default: pei_ovr_seconds = 4'h4;
    endcase
  endfunction

endpackage

// file: pei_sync.sv
`timescale 1ns/100ps
module pei_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: pei_filter.sv
`timescale 1ns/100ps
// output follows input only after it has been stable for LEN cycles
module pei_filter #(
  parameter int unsigned LEN = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 32'h0;
      q <= RST_VAL;
    end
    else if (d == q)
    begin
      cnt_r <= 32'h0;
    end
    else if (cnt_r + 32'h1 >= LEN)
    begin
      cnt_r <= 32'h0;
      q <= d;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule

// file: pei_plat.sv
`timescale 1ns/100ps
// ----
// platform side: power button
// ----
module pei_plat #(
  parameter int unsigned WAKE = 5,
  parameter int unsigned QUIET = 50
) (
  input wire logic clk,
  input wire logic rst,
  output logic power_button_n
);
  int quiet_left = 0;
  initial power_button_n = 1'b1;
  // no press until the quiet span after reset has run out
  always @(negedge clk)
    if (rst)
      quiet_left <= QUIET;
    else if (quiet_left > 0)
      quiet_left <= quiet_left - 1;
  task automatic push(input int n);
    while (quiet_left > 0)
      @(negedge clk);
    power_button_n = 1'b0;
    repeat ((n < WAKE) ? WAKE : n) @(negedge clk);
    power_button_n = 1'b1;
  endtask
endmodule

// file: pei_monitor.sv
`timescale 1ns/100ps
module pei_monitor #(
  parameter int unsigned HOST_RST_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_button_n,
  input wire logic hub_power_ok,
  input wire logic sleep_always_on_n,
  input wire logic in_s0,
  input wire pei_pkg::pei_cfg_t cfg,
  input wire logic button_level_status,
  input wire logic button_event_status,
  input wire logic button_wake,
  input wire logic override_soft_off,
  input wire logic host_reset,
  input wire logic full_power_cycle,
  input wire pei_pkg::pei_sleep_t sleep_out,
  input wire logic prior_trip_status,
  input wire logic resume_hold,
  input wire logic flash_block
);
  // ----
  // helpers
  // ----
  int unsigned hr_len_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // counts the cycles of the running host reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hr_len_r <= 0;
    else
      hr_len_r <= host_reset ? hr_len_r + 1 : 0;
  // ----
  // checks
  // ----
  hold_len_a: assert property (
    $fell(host_reset) |-> hr_len_r == HOST_RST_CYCLES)
    else $error("host reset length wrong");
  power_cycle_a: assert property (
    $rose(host_reset) |-> full_power_cycle == $past(cfg.reset_control[3]))
    else $error("power cycle kind wrong");
  reset_power_a: assert property (
    $rose(host_reset) |-> $past(hub_power_ok, 3))
    else $error("host reset without power ok");
  trip_effect_a: assert property (
    $rose(prior_trip_status) |-> sleep_out == 3'h0 && !button_event_status)
    else $error("trip effect wrong");
  override_off_a: assert property (
    $rose(override_soft_off) && !in_s0 |=> sleep_out == 3'h0)
    else $error("override kept sleep outputs high");
  flash_sleep_a: assert property (
    (!sleep_always_on_n) [*4] |-> flash_block)
    else $error("flash open while sleeping");
  hold_flash_a: assert property (
    resume_hold |-> flash_block)
    else $error("flash open during holdoff");
  wake_pulse_a: assert property (
    button_wake |=> !button_wake)
    else $error("wake pulse too long");
  raw_level_a: assert property (
    cfg.button_debounce_select && $past(cfg.button_debounce_select, 3)
    |-> button_level_status == !$past(power_button_n, 3))
    else $error("raw level status wrong");
endmodule
bind pei_top pei_monitor #(.HOST_RST_CYCLES(HOST_RST_CYCLES)) mon (.clk, .rst,
  .power_button_n, .hub_power_ok, .sleep_always_on_n, .in_s0, .cfg,
  .button_level_status, .button_event_status, .button_wake, .override_soft_off,
  .host_reset, .full_power_cycle, .sleep_out, .prior_trip_status, .resume_hold,
  .flash_block);

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_button_n, reset_button_n = 1'b1, thermal_trip_n = 1'b1;
  logic pci_wake_n = 1'b1, internal_wake_req = 1'b0, platform_reset_n = 1'b0;
  logic processor_power_good = 1'b0, hub_power_ok = 1'b1, resume_holdoff_n = 1'b1;
  logic sleep_always_on_n = 1'b1, in_s0 = 1'b0, sx_entry = 1'b0, deep_sleep_ok = 1'b1;
  logic button_event_set = 1'b0, button_event_clear = 1'b0;
  logic wake_status_clear = 1'b0, trip_status_clear = 1'b0;
  pei_pkg::pei_cfg_t cfg = '0;
  logic button_level_status, button_event_status, button_wake, internal_wake_status;
  logic pci_wake_event, override_soft_off, override_deep_sleep, host_reset;
  logic full_power_cycle, prior_trip_status, resume_hold, flash_block;
  pei_pkg::pei_sleep_t sleep_out;
  int n_fail = 0, check_count = 0, n_wk, n_pw, n_ov, n_dp, n_hr, n_lv, t;
  initial forever #50 clk = ~clk;
  pei_top #(.DEBOUNCE_CYCLES(20), .HOST_RST_CYCLES(50), .SEC_CYCLES(10),
    .WAKE_CYCLES(5)) dut (.clk, .rst, .power_button_n, .reset_button_n,
    .thermal_trip_n, .pci_wake_n, .internal_wake_req, .platform_reset_n,
    .processor_power_good, .hub_power_ok, .resume_holdoff_n, .sleep_always_on_n,
    .in_s0, .sx_entry, .deep_sleep_ok, .cfg, .button_event_set, .button_event_clear,
    .wake_status_clear, .trip_status_clear, .button_level_status,
    .button_event_status, .button_wake, .internal_wake_status, .pci_wake_event,
    .override_soft_off, .override_deep_sleep, .host_reset, .full_power_cycle,
    .sleep_out, .prior_trip_status, .resume_hold, .flash_block);
  pei_plat #(.WAKE(5), .QUIET(50)) plat (.clk, .rst, .power_button_n);
  // ----
  // event counters
  // ----
  always @(posedge clk)
  begin
    n_wk += button_wake;
    n_pw += pci_wake_event;
    n_ov += override_soft_off;
    n_dp += override_deep_sleep;
    n_hr += host_reset;
    n_lv += button_level_status;
  end
  // ----
  // tasks
  // ----
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // press the reset button, expect a host reset of len cycles
  task automatic rb(input logic [7:0] len, input logic fpc);
    n_hr = 0;
    reset_button_n = 1'b0;
    w(7);
    if (len != 8'h0)
      chk("full_power_cycle", {7'h0, fpc}, {7'h0, full_power_cycle});
    reset_button_n = 1'b1;
    w(70);
    chk("host_reset_len", len, 8'(n_hr));
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // ----
  // tests
  // ----
  initial
  begin
    w(3);
    chk("sleep_out_rst", 8'h07, {5'h0, sleep_out});
    chk("flash_block_rst", 8'h01, {7'h0, flash_block});
    rst = 1'b0;
    w(5);
    n_pw = 0;
    pci_wake_n = 1'b0;
    w(8);
    pci_wake_n = 1'b1;
    w(8);
    chk("pci_wake_events", 8'h01, 8'(n_pw));
    internal_wake_req = 1'b1;
    w(1);
    internal_wake_req = 1'b0;
    w(3);
    chk("internal_wake_status", 8'h01, {7'h0, internal_wake_status});
    wake_status_clear = 1'b1;
    w(1);
    wake_status_clear = 1'b0;
    w(3);
    chk("internal_wake_clear", 8'h00, {7'h0, internal_wake_status});
    cfg.button_debounce_select = 1'b1;
    n_wk = 0;
    n_lv = 0;
    plat.push(8);
    w(6);
    chk("raw_level_len", 8'h08, 8'(n_lv));
    chk("button_wake", 8'h01, 8'(n_wk));
    cfg.button_debounce_select = 1'b0;
    n_lv = 0;
    plat.push(15);
    w(25);
    chk("short_level", 8'h00, 8'(n_lv));
    plat.push(30);
    w(25);
    chk("long_level", 8'h01, {7'h0, n_lv != 0});
    cfg.button_debounce_select = 1'b1;
    hub_power_ok = 1'b0;
    for (int s = 0; s < 8; s++)
    begin
      cfg.override_period_select = 3'(s);
      deep_sleep_ok = s[0];
      t = (s > 0 && s < 6) ? 40 + 20 * s : 40;
      n_ov = 0;
      n_dp = 0;
      // gaps outlast the debounce, else the filter bridges two presses
      plat.push(t - 6);
      w(25);
      plat.push(t - 6);
      w(25);
      chk("override_early", 8'h00, 8'(n_ov));
      plat.push(t + 10);
      w(25);
      chk("override_hit", 8'h01, {7'h0, n_ov != 0});
      chk("override_deep", {7'h0, deep_sleep_ok}, {7'h0, n_dp != 0});
    end
    hub_power_ok = 1'b1;
    platform_reset_n = 1'b1;
    cfg.reset_control = 8'h08;
    w(5);
    rb(8'h32, 1'b1);
    rb(8'h00, 1'b0);
    in_s0 = 1'b1;
    cfg.reset_control = 8'h00;
    w(5);
    rb(8'h32, 1'b0);
    hub_power_ok = 1'b0;
    w(5);
    rb(8'h00, 1'b0);
    in_s0 = 1'b0;
    platform_reset_n = 1'b0;
    processor_power_good = 1'b1;
    button_event_set = 1'b1;
    w(1);
    button_event_set = 1'b0;
    button_event_clear = 1'b1;
    w(1);
    button_event_clear = 1'b0;
    w(2);
    chk("button_event_clear", 8'h00, {7'h0, button_event_status});
    button_event_set = 1'b1;
    w(1);
    button_event_set = 1'b0;
    w(2);
    chk("button_event_set", 8'h01, {7'h0, button_event_status});
    // valid point 0 with platform reset still low: window stays shut
    thermal_trip_n = 1'b0;
    w(10);
    chk("trip_before_window", 8'h00, {7'h0, prior_trip_status});
    thermal_trip_n = 1'b1;
    w(6);
    cfg.trip_valid_point = 1'b1;
    w(5);
    // short low that straddles a rising edge
    #40 thermal_trip_n = 1'b0;
    #20 thermal_trip_n = 1'b1;
    w(10);
    chk("trip_glitch", 8'h00, {7'h0, prior_trip_status});
    thermal_trip_n = 1'b0;
    w(10);
    chk("trip_status", 8'h01, {7'h0, prior_trip_status});
    chk("trip_sleep", 8'h00, {5'h0, sleep_out});
    chk("trip_button_event", 8'h00, {7'h0, button_event_status});
    thermal_trip_n = 1'b1;
    w(6);
    trip_status_clear = 1'b1;
    w(1);
    trip_status_clear = 1'b0;
    processor_power_good = 1'b0;
    w(5);
    thermal_trip_n = 1'b0;
    w(10);
    chk("trip_closed", 8'h00, {7'h0, prior_trip_status});
    thermal_trip_n = 1'b1;
    cfg.holdoff_enable = 1'b1;
    sleep_always_on_n = 1'b0;
    w(3);
    sx_entry = 1'b1;
    w(1);
    sx_entry = 1'b0;
    w(5);
    // controller sees no flash traffic in its window, then holds off
    chk("flash_sleep", 8'h01, {7'h0, flash_block});
    resume_holdoff_n = 1'b0;
    w(3);
    sleep_always_on_n = 1'b1;
    w(5);
    chk("resume_hold", 8'h01, {7'h0, resume_hold});
    chk("flash_hold", 8'h01, {7'h0, flash_block});
    resume_holdoff_n = 1'b1;
    w(5);
    chk("hold_release", 8'h00, {6'h0, resume_hold, flash_block});
    in_s0 = 1'b1;
    w(3);
    resume_holdoff_n = 1'b0;
    w(5);
    chk("hold_ignored", 8'h00, {7'h0, resume_hold});
    end_of_test();
  end
endmodule
